// ### pfm_fault_mgr.sv
// top: fault gathering, off-mode control and restart watchdog selection
module pfm_fault_mgr #(
  parameter int unsigned BO_BLANK_CYC = pfm_pkg::BO_BLANK_CYC,
  parameter int unsigned BO_WIN_CYC = pfm_pkg::BO_WIN_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic timing_current_low_i,
  input wire logic bo_sense_low_i,
  input wire logic output_undervoltage_protect_i,
  input wire logic latch_off_i,
  input wire logic overtemp_fault_i,
  input wire logic supply_lockout_i,
  input wire logic gate_a_i,
  input wire logic gate_b_i,
  input wire logic on_time_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic gate_a_o,
  output logic gate_b_o,
  output logic on_time_processing_o,
  output logic power_ready_out_o,
  output logic control_node_gnd_o,
  output logic bo_hyst_src_en_o,
  output logic bo_pulldown_o,
  output logic bo_hold_o,
  output logic brownout_fault_flag_o,
  output logic timing_pin_open_fault_o,
  output logic off_mode_o,
  output logic wd_fast_o,
  output logic [pfm_pkg::CNT_W-1:0] wd_limit_o
);
  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic [pfm_pkg::NSRC-1:0] raw_in;
  logic [pfm_pkg::NSRC-1:0] syn;
  assign raw_in = {supply_lockout_i, timing_current_low_i, overtemp_fault_i,
                   latch_off_i, output_undervoltage_protect_i,
                   bo_sense_low_i};
  genvar gi;
  generate
    for (gi = 0; gi < pfm_pkg::NSRC; gi++) begin : g_sync
      pfm_sync3 u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i(raw_in[gi]),
        // lockout reads as present through reset, so nothing starts early
        .rst_val_i(gi == pfm_pkg::SRC_SUPPLY_LOCKOUT),
        .q_o(syn[gi])
      );
    end
  endgenerate
  logic rt_low;
  logic bo_low;
  logic lockout;
  assign rt_low = syn[pfm_pkg::SRC_RT];
  assign bo_low = syn[pfm_pkg::SRC_BO];
  assign lockout = syn[pfm_pkg::SRC_SUPPLY_LOCKOUT];

  // ------------------------------------------------------------------
  // timing-pin-open blanking and latch
  // ------------------------------------------------------------------
  logic [pfm_pkg::CNT_W-1:0] rt_cnt_q;
  logic timing_pin_open_fault_q;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rt_cnt_q <= '0;
    end else if (!rt_low) begin
      rt_cnt_q <= '0;
    end else if (rt_cnt_q < pfm_pkg::CNT_W'(pfm_pkg::RT_BLANK_CYC)) begin
      rt_cnt_q <= rt_cnt_q + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      timing_pin_open_fault_q <= 1'b0;
    end else if (lockout) begin
      timing_pin_open_fault_q <= 1'b0;
    end else if (rt_cnt_q == pfm_pkg::CNT_W'(pfm_pkg::RT_BLANK_CYC)) begin
      timing_pin_open_fault_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // brown-out blanking and detection window
  // ------------------------------------------------------------------
  pfm_pkg::pfm_bo_state_t bo_st_q;
  logic [31:0] bo_cnt_q;
  logic bo_fault_q;
  always_ff @(posedge clk_i) begin
    if (!resetn_i || lockout) begin
      bo_st_q <= pfm_pkg::PFM_BO_FAULT;
      bo_cnt_q <= '0;
    end else begin
      unique case (bo_st_q)
        pfm_pkg::PFM_BO_IDLE: begin
          bo_cnt_q <= '0;
          if (bo_low) begin
            bo_st_q <= pfm_pkg::PFM_BO_BLANK;
          end
        end
        pfm_pkg::PFM_BO_BLANK: begin
          if (bo_cnt_q >= BO_BLANK_CYC - 1) begin
            bo_cnt_q <= '0;
            bo_st_q <= pfm_pkg::PFM_BO_WIN;
          end else begin
            bo_cnt_q <= bo_cnt_q + 1;
          end
        end
        pfm_pkg::PFM_BO_WIN: begin
          if (bo_low) begin
            bo_st_q <= pfm_pkg::PFM_BO_FAULT;
          end else if (bo_cnt_q >= BO_WIN_CYC - 1) begin
            bo_st_q <= pfm_pkg::PFM_BO_IDLE;
          end else begin
            bo_cnt_q <= bo_cnt_q + 1;
          end
        end
        pfm_pkg::PFM_BO_FAULT: begin
          bo_cnt_q <= '0;
          // stays until the line recovers
          if (!bo_low) begin
            bo_st_q <= pfm_pkg::PFM_BO_IDLE;
          end
        end
      endcase
    end
  end
  assign bo_fault_q = (bo_st_q == pfm_pkg::PFM_BO_FAULT);

  // ------------------------------------------------------------------
  // off-mode decision
  // ------------------------------------------------------------------
  logic [pfm_pkg::NSRC-1:0] src;
  logic off_d;
  logic off_q;
  logic started_q;
  assign src = {lockout, timing_pin_open_fault_q, syn[pfm_pkg::SRC_OT],
               syn[pfm_pkg::SRC_LATCH], syn[pfm_pkg::SRC_UVP], bo_fault_q};
  assign off_d = |src;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      off_q <= 1'b1;
      started_q <= 1'b0;
    end else begin
      off_q <= off_d;
      if (!lockout) begin
        started_q <= 1'b1;
      end else begin
        started_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs forced by off mode, plus brown-out pin control and fault flags
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gate_a_o <= 1'b0;
      gate_b_o <= 1'b0;
      on_time_processing_o <= 1'b0;
      power_ready_out_o <= 1'b0;
      control_node_gnd_o <= 1'b1;
      bo_hyst_src_en_o <= 1'b0;
      bo_pulldown_o <= 1'b1;
      bo_hold_o <= 1'b0;
      brownout_fault_flag_o <= 1'b1;
      timing_pin_open_fault_o <= 1'b0;
      off_mode_o <= 1'b1;
    end else begin
      gate_a_o <= gate_a_i & ~off_d;
      gate_b_o <= gate_b_i & ~off_d;
      on_time_processing_o <= on_time_i & ~off_d;
      power_ready_out_o <= ~off_d;
      control_node_gnd_o <= off_d;
      // source on in off mode with supply good, idle at startup lockout
      bo_hyst_src_en_o <= off_d & ~lockout & started_q;
      bo_pulldown_o <= lockout;
      bo_hold_o <= (bo_st_q == pfm_pkg::PFM_BO_BLANK) ||
                   (bo_st_q == pfm_pkg::PFM_BO_WIN);
      brownout_fault_flag_o <= bo_fault_q;
      timing_pin_open_fault_o <= timing_pin_open_fault_q;
      off_mode_o <= off_d;
    end
  end

  // ------------------------------------------------------------------
  // restart watchdog selection
  // ------------------------------------------------------------------
  logic fast_q;
  logic [pfm_pkg::CNT_W-1:0] wd_cnt_q;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      fast_q <= 1'b1;
      wd_cnt_q <= '0;
    end else if (off_d) begin
      fast_q <= 1'b1;
      wd_cnt_q <= '0;
    end else if (fast_q) begin
      // the first interval after recovery is the short one
      if (wd_cnt_q >= pfm_pkg::CNT_W'(pfm_pkg::WD_FAST_CYC - 1)) begin
        fast_q <= 1'b0;
        wd_cnt_q <= '0;
      end else begin
        wd_cnt_q <= wd_cnt_q + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wd_fast_o <= 1'b1;
      wd_limit_o <= pfm_pkg::CNT_W'(pfm_pkg::WD_FAST_CYC);
    end else begin
      wd_fast_o <= fast_q;
      wd_limit_o <= fast_q ? pfm_pkg::CNT_W'(pfm_pkg::WD_FAST_CYC)
                           : pfm_pkg::CNT_W'(pfm_pkg::WD_NORM_CYC);
    end
  end

  // ------------------------------------------------------------------
  // interrupt status, mask and register port
  // ------------------------------------------------------------------
  logic [pfm_pkg::NSRC-1:0] src_q;
  logic [pfm_pkg::NSRC-1:0] stat_q;
  logic [pfm_pkg::NSRC-1:0] mask_q;
  logic [pfm_pkg::NSRC-1:0] rise;
  logic [pfm_pkg::NSRC-1:0] clr;
  assign rise = src & ~src_q;
  assign clr = (wr_i && addr_i == pfm_pkg::ADDR_STATUS) ?
               wdata_i[pfm_pkg::NSRC-1:0] : '0;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      src_q <= '0;
      stat_q <= '0;
    end else begin
      src_q <= src;
      // a new event beats a clear in the same cycle
      stat_q <= (stat_q & ~clr) | rise;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mask_q <= pfm_pkg::MASK_RST;
    end else if (wr_i && addr_i == pfm_pkg::ADDR_MASK) begin
      mask_q <= wdata_i[pfm_pkg::NSRC-1:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
      rdata_o <= '0;
    end else begin
      irq_o <= |(((stat_q & ~clr) | rise) & mask_q);
      if (rd_i) begin
        unique case (addr_i)
          pfm_pkg::ADDR_STATUS: rdata_o <= {26'h0, stat_q};
          pfm_pkg::ADDR_MASK: rdata_o <= {26'h0, mask_q};
          pfm_pkg::ADDR_STATE: rdata_o <= {24'h0, fast_q, off_q, src};
          default: rdata_o <= 32'h0;
        endcase
      end else begin
        rdata_o <= 32'h0;
      end
    end
  end
endmodule

// ### pfm_pkg.sv
// package: constants for the fault and off-mode manager
package pfm_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned RT_BLANK_US = 30;
  localparam int unsigned RT_BLANK_CYC = RT_BLANK_US * CLK_MHZ;
  localparam int unsigned BO_BLANK_MS = 50;
  localparam int unsigned BO_BLANK_CYC = BO_BLANK_MS * 1000 * CLK_MHZ;
  localparam int unsigned BO_WIN_MS = 50;
  localparam int unsigned BO_WIN_CYC = BO_WIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned WD_FAST_US = 20;
  localparam int unsigned WD_FAST_CYC = WD_FAST_US * CLK_MHZ;
  localparam int unsigned WD_NORM_US = 200;
  localparam int unsigned WD_NORM_CYC = WD_NORM_US * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned NSRC = 6;
  // fault source bit positions
  localparam int unsigned SRC_BO = 0;
  localparam int unsigned SRC_UVP = 1;
  localparam int unsigned SRC_LATCH = 2;
  localparam int unsigned SRC_OT = 3;
  localparam int unsigned SRC_RT = 4;
  localparam int unsigned SRC_SUPPLY_LOCKOUT = 5;
  // register map
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_STATE = 4'h8;
  localparam logic [5:0] MASK_RST = 6'h00;
  typedef enum logic [1:0] {
    PFM_BO_IDLE,
    PFM_BO_BLANK,
    PFM_BO_WIN,
    PFM_BO_FAULT
  } pfm_bo_state_t;
endpackage

// ### pfm_sync3.sv
// three-stage input synchroniser with second/third agreement
module pfm_sync3 (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic d_i,
  input wire logic rst_val_i,
  output logic q_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      // each stage starts at the level the source is assumed to hold
      s1_q <= rst_val_i;
      s2_q <= rst_val_i;
      s3_q <= rst_val_i;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // output moves only once two stages agree
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      q_o <= rst_val_i;
    end else if (s2_q == s3_q) begin
      q_o <= s3_q;
    end
  end
endmodule

// ### pfm_fault_mgr_asserts.sv
// checker: off-mode, latch and watchdog relations at the top ports
module pfm_fault_mgr_asserts (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic timing_current_low_i,
  input wire logic supply_lockout_i,
  input wire logic gate_a_i,
  input wire logic gate_b_i,
  input wire logic gate_a_o,
  input wire logic gate_b_o,
  input wire logic on_time_processing_o,
  input wire logic power_ready_out_o,
  input wire logic control_node_gnd_o,
  input wire logic bo_hyst_src_en_o,
  input wire logic bo_pulldown_o,
  input wire logic timing_pin_open_fault_o,
  input wire logic off_mode_o,
  input wire logic wd_fast_o,
  input wire logic [23:0] wd_limit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ------------------------------------------------------------
  // helper: run length of the raw low-current level
  // ------------------------------------------------------------
  logic [11:0] low_cnt_q;
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !timing_current_low_i) begin
      low_cnt_q <= 12'h000;
    end else if (low_cnt_q != 12'hFFF) begin
      low_cnt_q <= low_cnt_q + 12'h001;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_gate_follow: assert property (
    gate_a_o == ($past(gate_a_i) && !off_mode_o) &&
    gate_b_o == ($past(gate_b_i) && !off_mode_o)) else $error("gate wrong");
  a_ontime_zero: assert property (
    off_mode_o |-> !on_time_processing_o) else $error("on-time not zero");
  a_ready_off: assert property (
    power_ready_out_o != off_mode_o) else $error("ready wrong");
  a_ctrl_ground: assert property (
    control_node_gnd_o == off_mode_o) else $error("control node wrong");
  a_hyst_source: assert property (
    bo_hyst_src_en_o |-> off_mode_o && !bo_pulldown_o)
    else $error("hysteresis source wrong");
  a_pin_off: assert property (
    timing_pin_open_fault_o |=> off_mode_o) else $error("pin fault not off");
  a_pin_hold: assert property (
    (!supply_lockout_i [*6] ##0 timing_pin_open_fault_o)
    |=> timing_pin_open_fault_o) else $error("pin latch dropped");
  a_pin_blank: assert property (
    $rose(timing_pin_open_fault_o) |-> low_cnt_q >= 12'hBB0)
    else $error("pin latch set early");
  a_wd_select: assert property (
    wd_limit_o == (wd_fast_o ? 24'h0007D0 : 24'h004E20))
    else $error("watchdog limit wrong");
  a_wd_first: assert property (
    $fell(off_mode_o) |-> wd_fast_o [*8]) else $error("no fast restart");
  c_pin_set: cover property ($rose(timing_pin_open_fault_o));
  c_off_end: cover property ($fell(off_mode_o));
  c_wd_norm: cover property ($fell(wd_fast_o));
endmodule

bind pfm_fault_mgr pfm_fault_mgr_asserts u_pfm_fault_mgr_asserts (.*);

// ### pfm_pwm_model.sv
// partner: free-running two-phase gate request source
module pfm_pwm_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  output logic gate_a_o,
  output logic gate_b_o,
  output logic on_time_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_q;
  // keeps running in off mode, so any leak through the gating shows
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ph_q <= 3'h0;
    end else begin
      ph_q <= ph_q + 3'h1;
    end
  end
  assign gate_a_o = ph_q < 3'h3;
  assign gate_b_o = ph_q >= 3'h4 && ph_q < 3'h7;
  assign on_time_o = ph_q[0];
endmodule

// ### tb_pfm_fault_mgr.sv
// testbench: fault manager sequences through the register port
module tb_pfm_fault_mgr;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [5:0] src = 6'h20;
  logic gate_a_i, gate_b_i, on_time_i;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [23:0] wd_limit_o;
  logic irq_o, gate_a_o, gate_b_o, on_time_processing_o, power_ready_out_o;
  logic control_node_gnd_o, bo_hyst_src_en_o, bo_pulldown_o, bo_hold_o;
  logic brownout_fault_flag_o, timing_pin_open_fault_o, off_mode_o, wd_fast_o;
  int failures = 0;
  int check_count = 0;
  pfm_fault_mgr #(.BO_BLANK_CYC(20), .BO_WIN_CYC(20)) u_pfm_fault_mgr (
    .clk_i, .resetn_i, .timing_current_low_i(src[4]),
    .bo_sense_low_i(src[0]), .output_undervoltage_protect_i(src[1]),
    .latch_off_i(src[2]), .overtemp_fault_i(src[3]),
    .supply_lockout_i(src[5]), .gate_a_i, .gate_b_i, .on_time_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .gate_a_o,
    .gate_b_o, .on_time_processing_o, .power_ready_out_o,
    .control_node_gnd_o, .bo_hyst_src_en_o, .bo_pulldown_o, .bo_hold_o,
    .brownout_fault_flag_o, .timing_pin_open_fault_o, .off_mode_o,
    .wd_fast_o, .wd_limit_o);
  pfm_pwm_model u_pfm_pwm_model (.clk_i, .resetn_i, .gate_a_o(gate_a_i),
    .gate_b_o(gate_b_i), .on_time_o(on_time_i));
  always #5 clk_i = ~clk_i;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input logic [15:0] n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, e);
  endtask
  task automatic st(input logic o);
    check(off_mode_o, o);
    check({power_ready_out_o, control_node_gnd_o}, {!o, o});
    if (o) check({gate_a_o, gate_b_o}, 2'h0);
    if (o) check(on_time_processing_o, 1'b0);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    results();
  end
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    wt(16'h2);
    check({brownout_fault_flag_o, bo_pulldown_o}, 2'h3);
    check(bo_hyst_src_en_o, 1'b0);
    check(wd_limit_o, 24'h0007D0);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    wt(16'hA);
    check({brownout_fault_flag_o, bo_hyst_src_en_o}, 2'h2);
    src <= 6'h00;
    wt(16'hC);
    st(1'b0);
    check(wd_limit_o, 24'h0007D0);
    wt(16'h834);
    check(wd_limit_o, 24'h004E20);
    wr(4'h0, 32'h3F);
    wr(4'h4, 32'h3F);
    rd(4'h4, 32'h3F);
    rd(4'h8, 32'h0);
    rd(4'hC, 32'h0);
    for (int i = 1; i < 4; i++) begin
      src[i] <= 1'b1;
      wt(16'h8);
      st(1'b1);
      check({bo_hyst_src_en_o, irq_o}, 2'h3);
      rd(4'h0, 32'h1 << i);
      src[i] <= 1'b0;
      wt(16'h8);
      wr(4'h0, 32'h1 << i);
      wt(16'h2);
      check(irq_o, 1'b0);
      st(1'b0);
      check(wd_fast_o, 1'b1);
    end
    src[3] <= 1'b1;
    wr(4'h4, 32'h0);
    wt(16'h8);
    check(irq_o, 1'b0);
    wr(4'h4, 32'h3F);
    wt(16'h2);
    check(irq_o, 1'b1);
    src[3] <= 1'b0;
    wt(16'h8);
    src[4] <= 1'b1;
    wt(16'h3E8);
    src[4] <= 1'b0;
    wt(16'h8);
    check({timing_pin_open_fault_o, off_mode_o}, 2'h0);
    src[4] <= 1'b1;
    wt(16'hBAE);
    check(timing_pin_open_fault_o, 1'b0);
    wt(16'h1E);
    check(timing_pin_open_fault_o, 1'b1);
    src[4] <= 1'b0;
    wt(16'h32);
    check(timing_pin_open_fault_o, 1'b1);
    st(1'b1);
    src[5] <= 1'b1;
    wt(16'h8);
    check(timing_pin_open_fault_o, 1'b0);
    check({bo_pulldown_o, bo_hyst_src_en_o}, 2'h2);
    st(1'b1);
    src[5] <= 1'b0;
    wt(16'hC);
    st(1'b0);
    src[0] <= 1'b1;
    wt(16'hE);
    check({brownout_fault_flag_o, off_mode_o}, 2'h0);
    check(bo_hold_o, 1'b1);
    src[0] <= 1'b0;
    wt(16'h3C);
    src[0] <= 1'b1;
    wt(16'h46);
    check(brownout_fault_flag_o, 1'b1);
    st(1'b1);
    src[0] <= 1'b0;
    wt(16'hC);
    st(1'b0);
    results();
  end
endmodule
